// ===== sim/echo_ctl_properties.sv
// assertion checker for the echo group main control block
`default_nettype none
module echo_ctl_checker (
  input wire logic REF_CLK_I,
  input wire logic SYS_RST_I,
  input wire logic S_AXI_AWVALID_I,
  input wire logic S_AXI_AWREADY_O,
  input wire logic S_AXI_WVALID_I,
  input wire logic S_AXI_WREADY_O,
  input wire logic [1:0] S_AXI_BRESP_O,
  input wire logic S_AXI_BVALID_O,
  input wire logic S_AXI_BREADY_I,
  input wire logic S_AXI_ARVALID_I,
  input wire logic S_AXI_ARREADY_O,
  input wire logic S_AXI_RVALID_O,
  input wire logic OUTPUT_DRIVE_PIN_I,
  input wire logic [3:0] RX_OUT_OE_O,
  input wire logic [3:0] TX_OUT_OE_O,
  input wire logic [3:0] GRP_ACTIVE_O,
  input wire logic [3:0] COEF_CLEAR_O
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking @(posedge REF_CLK_I); endclocking
  default disable iff (SYS_RST_I);
  // ====
  // assertions
  oe_needs_pin_a: assert property (|RX_OUT_OE_O |-> $past(OUTPUT_DRIVE_PIN_I, 2))
    else $error("output drive without pin");
  oe_pair_a: assert property (RX_OUT_OE_O == TX_OUT_OE_O)
    else $error("receive and send drive differ");
  oe_one_bit_a: assert property (RX_OUT_OE_O == 4'h0 || RX_OUT_OE_O == 4'hF)
    else $error("drive differs between groups");
  wr_answer_a: assert property (S_AXI_AWVALID_I && S_AXI_AWREADY_O && S_AXI_WVALID_I && S_AXI_WREADY_O
    |-> ##2 S_AXI_BVALID_O)
    else $error("write answer late");
  b_hold_a: assert property (S_AXI_BVALID_O && !S_AXI_BREADY_I |=> S_AXI_BVALID_O && $stable(S_AXI_BRESP_O))
    else $error("write answer dropped");
  rd_answer_a: assert property (S_AXI_ARVALID_I && S_AXI_ARREADY_O |-> ##2 S_AXI_RVALID_O)
    else $error("read answer late");
  busy_not_active_a: assert property ((GRP_ACTIVE_O & COEF_CLEAR_O) == 4'h0)
    else $error("group active during init");
  init_then_active_a: assert property ($fell(COEF_CLEAR_O[3]) |-> ##[0:1] GRP_ACTIVE_O[3])
    else $error("group idle after init");
  init_c: cover property ($rose(COEF_CLEAR_O[3]));
  drive_c: cover property ($rose(RX_OUT_OE_O[0]));
  read_c: cover property (S_AXI_ARVALID_I && S_AXI_ARREADY_O);
endmodule // echo_ctl_checker

bind echo_group_main_control echo_ctl_checker chk (.REF_CLK_I, .SYS_RST_I, .S_AXI_AWVALID_I, .S_AXI_AWREADY_O,
  .S_AXI_WVALID_I, .S_AXI_WREADY_O, .S_AXI_BRESP_O, .S_AXI_BVALID_O, .S_AXI_BREADY_I, .S_AXI_ARVALID_I,
  .S_AXI_ARREADY_O, .S_AXI_RVALID_O, .OUTPUT_DRIVE_PIN_I, .RX_OUT_OE_O, .TX_OUT_OE_O, .GRP_ACTIVE_O,
  .COEF_CLEAR_O);
`default_nettype wire

// ===== sim/echo_group_main_control_tb.sv
// self-checking bench for the echo group main control block
`include "echo_ctl_regs.vh"
`default_nettype none
module echo_group_main_control_tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk = 1'b0, rst = 1'b1, awv = 1'b0, wv = 1'b0, bready = 1'b0, arv = 1'b0, rready = 1'b0;
  logic pin = 1'b0, frame = 1'b0;
  logic [11:0] awaddr = 12'h000, araddr = 12'h000;
  logic [31:0] wdata = 32'h00000000;
  logic [3:0] tone_a = 4'h0, tone_b = 4'h0, rx_in = 4'h0, tx_in = 4'h0;
  logic [6:0] fcnt = 7'h00;
  wire awr, wr, bv, arr, rv, irq;
  wire [1:0] bresp, rresp;
  wire [31:0] rdata;
  wire [3:0] rx_out, rx_oe, tx_out, tx_oe, fmt, law, act, clr;
  int err_total = 0, cmp_count = 0;

  echo_group_main_control dut (.REF_CLK_I(clk), .SYS_RST_I(rst), .S_AXI_AWADDR_I(awaddr),
    .S_AXI_AWVALID_I(awv), .S_AXI_AWREADY_O(awr), .S_AXI_WDATA_I(wdata), .S_AXI_WSTRB_I(4'hF),
    .S_AXI_WVALID_I(wv), .S_AXI_WREADY_O(wr), .S_AXI_BRESP_O(bresp), .S_AXI_BVALID_O(bv),
    .S_AXI_BREADY_I(bready), .S_AXI_ARADDR_I(araddr), .S_AXI_ARVALID_I(arv), .S_AXI_ARREADY_O(arr),
    .S_AXI_RDATA_O(rdata), .S_AXI_RRESP_O(rresp), .S_AXI_RVALID_O(rv), .S_AXI_RREADY_I(rready),
    .OUTPUT_DRIVE_PIN_I(pin), .FRAME_PULSE_I(frame), .TONE_A_EVT_I(tone_a), .TONE_B_EVT_I(tone_b),
    .RX_IN_I(rx_in), .TX_IN_I(tx_in), .RX_OUT_O(rx_out), .RX_OUT_OE_O(rx_oe), .TX_OUT_O(tx_out),
    .TX_OUT_OE_O(tx_oe), .FMT_G711_O(fmt), .LAW_ALAW_O(law), .GRP_ACTIVE_O(act), .COEF_CLEAR_O(clr),
    .IRQ_O(irq));

  // ====
  // clock and frame marker, high 32 of every 128 cycles so a preset sweep fits in a frame
  always #5 clk = ~clk;
  always @(posedge clk) begin
    fcnt <= fcnt + 7'h01;
    frame <= fcnt[6] & fcnt[5];
  end

  // ====
  // shared tasks
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] s);
    cmp_count++;
    if (s !== e) begin
      err_total++;
      $display("[FAIL] %s expected %h seen %h", nm, e, s);
    end
  endtask

  task automatic axw(input logic [11:0] a, input logic [7:0] d, input logic [1:0] er = `AXI_OKAY);
    int n;
    n = 0;
    awaddr <= a;
    wdata <= {24'h000000, d};
    awv <= 1'b1;
    wv <= 1'b1;
    bready <= 1'b1;
    do begin
      @(posedge clk);
      if (awv && awr) awv <= 1'b0;
      if (wv && wr) wv <= 1'b0;
      n++;
    end while (bv !== 1'b1 && n < 100);
    bready <= 1'b0;
    chk("bvalid", 32'h1, {31'h0, bv});
    chk("bresp", {30'h0, er}, {30'h0, bresp});
    @(posedge clk);
  endtask

  task automatic axr(input logic [11:0] a, input logic [7:0] d, input logic [1:0] er = `AXI_OKAY);
    int n;
    n = 0;
    araddr <= a;
    arv <= 1'b1;
    rready <= 1'b1;
    do begin
      @(posedge clk);
      if (arv && arr) arv <= 1'b0;
      n++;
    end while (rv !== 1'b1 && n < 100);
    rready <= 1'b0;
    chk("rvalid", 32'h1, {31'h0, rv});
    chk("rdata", {24'h0, d}, rdata);
    chk("rresp", {30'h0, er}, {30'h0, rresp});
    @(posedge clk);
  endtask

  // one-cycle tone event, then the interrupt line
  task automatic tone(input logic [3:0] a, input logic [3:0] b, input logic e);
    tone_a <= a;
    tone_b <= b;
    @(posedge clk);
    tone_a <= 4'h0;
    tone_b <= 4'h0;
    repeat (5) @(posedge clk);
    chk("irq", {31'h0, e}, {31'h0, irq});
  endtask

  // power group 3 just after a frame and count frames until init ends
  task automatic pwr_on;
    int k, n;
    logic p;
    @(negedge frame);
    axw(`MAIN_CTL3_ADDR, 8'h01);
    @(posedge clk);
    chk("clear", 32'h8, {28'h0, clr});
    axr(`GRP_STAT_ADDR, 8'h88);
    k = 0;
    n = 0;
    p = frame;
    while (clr[3] === 1'b1 && n < 400) begin
      @(posedge clk);
      if (frame && !p) k++;
      p = frame;
      n++;
    end
    chk("frames", 32'd2, k);
    @(posedge clk);
    chk("active", 32'h8, {28'h0, act});
    axr(`GRP_STAT_ADDR, 8'h08);
  endtask

  task automatic end_sim;
    $display("comparisons %0d mismatches %0d", cmp_count, err_total);
    if (err_total == 0 && cmp_count > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask

  // ====
  // test sequence
  initial begin
    repeat (2) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    for (int g = 0; g < 4; g++) axr(12'(4 * g), 8'h00);
    axr(12'h020, 8'h00, `AXI_SLVERR);
    axw(12'h024, 8'h11, `AXI_SLVERR);
    axw(`MAIN_CTL1_ADDR, 8'hE6);
    axr(`MAIN_CTL1_ADDR, 8'h06);
    axw(`MAIN_CTL1_ADDR, 8'h00);
    for (int g = 0; g < 4; g++) begin
      axw(12'(4 * g), 8'h04);
      repeat (3) @(posedge clk);
      chk("format", 32'h1 << g, {28'h0, fmt});
      chk("law", 32'h0, {28'h0, law});
      axw(12'(4 * g), 8'h02);
      repeat (3) @(posedge clk);
      chk("law", 32'h1 << g, {28'h0, law});
      chk("format", 32'h0, {28'h0, fmt});
      axw(12'(4 * g), 8'h00);
    end
    pin <= 1'b1;
    axw(`MAIN_CTL0_ADDR, 8'h40);
    repeat (4) @(posedge clk);
    chk("drive", 32'hF, {28'h0, rx_oe});
    pin <= 1'b0;
    repeat (4) @(posedge clk);
    chk("drive", 32'h0, {28'h0, tx_oe});
    pin <= 1'b1;
    axw(`MAIN_CTL0_ADDR, 8'h00);
    axw(`MAIN_CTL1_ADDR, 8'h40);
    repeat (4) @(posedge clk);
    chk("drive", 32'h0, {28'h0, rx_oe});
    axr(`MAIN_CTL1_ADDR, 8'h00);
    axw(`INT_MASK_ADDR, 8'h00);
    tone(4'h2, 4'h0, 1'b1);
    axr(`INT_STAT_ADDR, 8'h02);
    axw(`INT_STAT_ADDR, 8'h02);
    chk("irq", 32'h0, {31'h0, irq});
    axw(`MAIN_CTL1_ADDR, 8'h08);
    tone(4'h2, 4'h0, 1'b0);
    axw(`INT_STAT_ADDR, 8'hFF);
    axw(`MAIN_CTL1_ADDR, 8'h10);
    tone(4'h0, 4'h2, 1'b0);
    tone(4'h2, 4'h0, 1'b1);
    axw(`INT_STAT_ADDR, 8'hFF);
    axw(`MAIN_CTL0_ADDR, 8'h20);
    tone(4'hF, 4'hF, 1'b0);
    axr(`INT_STAT_ADDR, 8'h00);
    axw(`MAIN_CTL0_ADDR, 8'h00);
    tone(4'h0, 4'h4, 1'b1);
    axr(`INT_STAT_ADDR, 8'h40);
    axw(`INT_MASK_ADDR, 8'hFF);
    chk("irq", 32'h0, {31'h0, irq});
    axw(`INT_STAT_ADDR, 8'h40);
    pwr_on;
    axr(12'hB14, 8'h00);
    axw(12'hB14, 8'h5A);
    axr(12'hB14, 8'h5A);
    axw(`MAIN_CTL3_ADDR, 8'h00);
    repeat (3) @(posedge clk);
    chk("active", 32'h0, {28'h0, act});
    pwr_on;
    axr(12'hB14, 8'h00);
    axw(`MAIN_CTL0_ADDR, 8'h80);
    axw(12'h808, 8'h33);
    for (int g = 1; g < 4; g++) axr(12'(12'h808 + 256 * g), 8'h33);
    axw(`MAIN_CTL0_ADDR, 8'h00);
    axw(12'h808, 8'h44);
    axr(12'h908, 8'h33);
    rx_in <= 4'hA;
    tx_in <= 4'h5;
    repeat (3) @(negedge frame);
    rx_in <= 4'h3;
    tx_in <= 4'hC;
    repeat (2) @(posedge clk);
    chk("rx out", 32'hA, {28'h0, rx_out});
    @(negedge frame);
    repeat (2) @(posedge clk);
    chk("tx out", 32'h5, {28'h0, tx_out});
    @(negedge frame);
    repeat (2) @(posedge clk);
    chk("rx out", 32'h3, {28'h0, rx_out});
    chk("tx out", 32'hC, {28'h0, tx_out});
    end_sim;
  end

  // watchdog far beyond the roughly 1400 cycles the tests need
  initial begin
    #200000;
    err_total++;
    end_sim;
  end
endmodule // echo_group_main_control_tb
`default_nettype wire

// ===== verilog/chan_mem.v
// per-channel register memory with registered read port and synchronous write port
`default_nettype none
module chan_mem #(
  parameter AW = 8
) (
  input wire clk_i,
  input wire we_i,
  input wire [AW-1:0] waddr_i,
  input wire [7:0] wdata_i,
  input wire [AW-1:0] raddr_i,
  output reg [7:0] rdata_o
);
  reg [7:0] mem [0:(1<<AW)-1];

  // synchronous write and registered read
  always @(posedge clk_i) begin
    if (we_i) begin
      mem[waddr_i] <= wdata_i;
    end
    rdata_o <= mem[raddr_i];
  end
endmodule // chan_mem
`default_nettype wire

// ===== verilog/echo_ctl_regs.vh
// register map, field positions and timing constants for the echo group main control block
`ifndef ECHO_CTL_REGS_VH
`define ECHO_CTL_REGS_VH
// main control register byte addresses (index 400..403 hex, word aligned)
`define MAIN_CTL0_ADDR 12'h000
`define MAIN_CTL1_ADDR 12'h004
`define MAIN_CTL2_ADDR 12'h008
`define MAIN_CTL3_ADDR 12'h00C
`define INT_STAT_ADDR 12'h010
`define INT_MASK_ADDR 12'h014
`define GRP_STAT_ADDR 12'h018
`define CHAN_REG_BASE 12'h800
`define CHAN_REG_TOP 12'hBFC
// main control field positions
`define BIT_BCAST 7
`define BIT_ODE 6
`define BIT_GMASK 5
`define BIT_MASKB 4
`define BIT_MASKA 3
`define BIT_FMT 2
`define BIT_LAW 1
`define BIT_PWR 0
`define MAIN_CTL_RST 8'h00
`define MAIN_CTL_MASK_G0 8'hFF
`define MAIN_CTL_MASK_GX 8'h1F
`define CHAN_DEFAULT 8'h00
`define CHAN_IDX_LAST 6'h3F
`define AXI_OKAY 2'h0
`define AXI_SLVERR 2'h2
// initialization takes two frames
`define INIT_FRAMES 2'h2
`endif

// ===== verilog/echo_group_main_control.v
// main control registers of four echo canceller groups with axi4-lite access
`include "echo_ctl_regs.vh"
`default_nettype none
module echo_group_main_control #(
  parameter NGRP = 4
) (
  input wire REF_CLK_I,
  input wire SYS_RST_I,
  input wire [11:0] S_AXI_AWADDR_I,
  input wire S_AXI_AWVALID_I,
  output wire S_AXI_AWREADY_O,
  input wire [31:0] S_AXI_WDATA_I,
  input wire [3:0] S_AXI_WSTRB_I,
  input wire S_AXI_WVALID_I,
  output wire S_AXI_WREADY_O,
  output reg [1:0] S_AXI_BRESP_O,
  output reg S_AXI_BVALID_O,
  input wire S_AXI_BREADY_I,
  input wire [11:0] S_AXI_ARADDR_I,
  input wire S_AXI_ARVALID_I,
  output wire S_AXI_ARREADY_O,
  output reg [31:0] S_AXI_RDATA_O,
  output reg [1:0] S_AXI_RRESP_O,
  output reg S_AXI_RVALID_O,
  input wire S_AXI_RREADY_I,
  input wire OUTPUT_DRIVE_PIN_I,
  input wire FRAME_PULSE_I,
  input wire [3:0] TONE_A_EVT_I,
  input wire [3:0] TONE_B_EVT_I,
  input wire [3:0] RX_IN_I,
  input wire [3:0] TX_IN_I,
  output reg [3:0] RX_OUT_O,
  output wire [3:0] RX_OUT_OE_O,
  output reg [3:0] TX_OUT_O,
  output wire [3:0] TX_OUT_OE_O,
  output reg [3:0] FMT_G711_O,
  output reg [3:0] LAW_ALAW_O,
  output reg [3:0] GRP_ACTIVE_O,
  output reg [3:0] COEF_CLEAR_O,
  output wire IRQ_O
);
  // ==========================================================
  // helpers
  function in_chan;
    input [11:0] a;
    begin
      in_chan = (a >= `CHAN_REG_BASE) && (a <= `CHAN_REG_TOP);
    end
  endfunction

  // ==========================================================
  // pin synchronisers
  reg [1:0] ode_pin_q;
  reg [1:0] frame_s_q;
  reg frame_d_q;
  reg [3:0] ta_s1_q, ta_s2_q, tb_s1_q, tb_s2_q;
  reg [3:0] ri_s1_q, ri_s2_q, ti_s1_q, ti_s2_q;

  // two flops on every pin before use
  always @(posedge REF_CLK_I) begin
    if (SYS_RST_I) begin
      ode_pin_q <= 2'h0;
      frame_s_q <= 2'h0;
      frame_d_q <= 1'b0;
      ta_s1_q <= 4'h0;
      ta_s2_q <= 4'h0;
      tb_s1_q <= 4'h0;
      tb_s2_q <= 4'h0;
      ri_s1_q <= 4'h0;
      ri_s2_q <= 4'h0;
      ti_s1_q <= 4'h0;
      ti_s2_q <= 4'h0;
    end else begin
      ode_pin_q <= {ode_pin_q[0], OUTPUT_DRIVE_PIN_I};
      frame_s_q <= {frame_s_q[0], FRAME_PULSE_I};
      frame_d_q <= frame_s_q[1];
      ta_s1_q <= TONE_A_EVT_I;
      ta_s2_q <= ta_s1_q;
      tb_s1_q <= TONE_B_EVT_I;
      tb_s2_q <= tb_s1_q;
      ri_s1_q <= RX_IN_I;
      ri_s2_q <= ri_s1_q;
      ti_s1_q <= TX_IN_I;
      ti_s2_q <= ti_s1_q;
    end
  end
  wire frame_tick = frame_s_q[1] & ~frame_d_q;

  // ==========================================================
  // axi4-lite write channel
  reg aw_got_q, w_got_q;
  reg [11:0] awaddr_q;
  reg [7:0] wdata_q;
  reg wlane_q;
  assign S_AXI_AWREADY_O = ~aw_got_q & ~S_AXI_BVALID_O;
  assign S_AXI_WREADY_O = ~w_got_q & ~S_AXI_BVALID_O;
  wire wr_go = aw_got_q & w_got_q;

  reg [7:0] main_q [0:3];
  reg [7:0] int_stat_q, int_mask_q;
  reg [3:0] init_busy_q;
  reg [1:0] init_cnt_q [0:3];
  reg [3:0] pwr_prev_q;
  wire bcast = main_q[0][`BIT_BCAST];
  wire wr_chan = wr_go & wlane_q & in_chan(awaddr_q);

  // address and data latched in either order, response after both
  always @(posedge REF_CLK_I) begin
    if (SYS_RST_I) begin
      aw_got_q <= 1'b0;
      w_got_q <= 1'b0;
      awaddr_q <= 12'h000;
      wdata_q <= 8'h00;
      wlane_q <= 1'b0;
      S_AXI_BVALID_O <= 1'b0;
      S_AXI_BRESP_O <= `AXI_OKAY;
    end else begin
      if (S_AXI_AWVALID_I && S_AXI_AWREADY_O) begin
        aw_got_q <= 1'b1;
        awaddr_q <= S_AXI_AWADDR_I;
      end
      if (S_AXI_WVALID_I && S_AXI_WREADY_O) begin
        w_got_q <= 1'b1;
        wdata_q <= S_AXI_WDATA_I[7:0];
        wlane_q <= S_AXI_WSTRB_I[0];
      end
      if (wr_go) begin
        aw_got_q <= 1'b0;
        w_got_q <= 1'b0;
        S_AXI_BVALID_O <= 1'b1;
        S_AXI_BRESP_O <= (awaddr_q <= `GRP_STAT_ADDR || in_chan(awaddr_q)) ? `AXI_OKAY : `AXI_SLVERR;
      end else if (S_AXI_BREADY_I) begin
        S_AXI_BVALID_O <= 1'b0;
      end
    end
  end

  // ==========================================================
  // main control registers, status and mask
  // each process owns its loop index so no variable has two drivers
  integer gi_ev, gi_reg, gi_pwr, gi_init, gi_pick, gi_swp, gi_out;
  reg [7:0] ev_d;
  always @* begin
    ev_d = 8'h00;
    for (gi_ev = 0; gi_ev < NGRP; gi_ev = gi_ev + 1) begin
      // global then per canceller masking of tone events
      ev_d[gi_ev] = ta_s2_q[gi_ev] & ~main_q[0][`BIT_GMASK] & ~main_q[gi_ev][`BIT_MASKA];
      ev_d[gi_ev+4] = tb_s2_q[gi_ev] & ~main_q[0][`BIT_GMASK] & ~main_q[gi_ev][`BIT_MASKB];
    end
  end

  always @(posedge REF_CLK_I) begin
    if (SYS_RST_I) begin
      for (gi_reg = 0; gi_reg < NGRP; gi_reg = gi_reg + 1) begin
        main_q[gi_reg] <= `MAIN_CTL_RST;
      end
      int_stat_q <= 8'h00;
      int_mask_q <= 8'h00;
    end else begin
      if (wr_go && wlane_q) begin
        for (gi_reg = 0; gi_reg < NGRP; gi_reg = gi_reg + 1) begin
          // only group 0 holds broadcast, drive and global mask bits
          if (awaddr_q == `MAIN_CTL0_ADDR + {gi_reg[9:0], 2'h0})
            main_q[gi_reg] <= wdata_q & ((gi_reg == 0) ? `MAIN_CTL_MASK_G0 : `MAIN_CTL_MASK_GX);
        end
        if (awaddr_q == `INT_MASK_ADDR)
          int_mask_q <= wdata_q;
      end
      // write one clears, a new event wins
      if (wr_go && wlane_q && awaddr_q == `INT_STAT_ADDR)
        int_stat_q <= (int_stat_q & ~wdata_q) | ev_d;
      else
        int_stat_q <= int_stat_q | ev_d;
    end
  end
  assign IRQ_O = |(int_stat_q & ~int_mask_q);

  // ==========================================================
  // power-up initialization per group
  reg [3:0] pwr;
  always @* begin
    pwr = 4'h0;
    for (gi_pwr = 0; gi_pwr < NGRP; gi_pwr = gi_pwr + 1) begin
      pwr[gi_pwr] = main_q[gi_pwr][`BIT_PWR];
    end
  end

  // rising power bit starts a two-frame init
  always @(posedge REF_CLK_I) begin
    if (SYS_RST_I) begin
      pwr_prev_q <= 4'h0;
      init_busy_q <= 4'h0;
      for (gi_init = 0; gi_init < NGRP; gi_init = gi_init + 1) begin
        init_cnt_q[gi_init] <= 2'h0;
      end
    end else begin
      pwr_prev_q <= pwr;
      for (gi_init = 0; gi_init < NGRP; gi_init = gi_init + 1) begin
        if (pwr[gi_init] && !pwr_prev_q[gi_init]) begin
          init_busy_q[gi_init] <= 1'b1;
          init_cnt_q[gi_init] <= 2'h0;
        end else if (!pwr[gi_init]) begin
          init_busy_q[gi_init] <= 1'b0;
        end else if (init_busy_q[gi_init] && frame_tick) begin
          if (init_cnt_q[gi_init] == `INIT_FRAMES - 2'h1)
            init_busy_q[gi_init] <= 1'b0;
          init_cnt_q[gi_init] <= init_cnt_q[gi_init] + 2'h1;
        end
      end
    end
  end

  // ==========================================================
  // per-channel registers, 64 per canceller pair of each group
  reg [5:0] clr_idx_q;
  reg [1:0] clr_grp_q;
  reg clr_act_q;
  reg [3:0] swept_q;
  wire [3:0] pwr_rise = pwr & ~pwr_prev_q;
  wire [3:0] need_clr = init_busy_q & ~swept_q;
  wire clr_go = |need_clr;
  wire clr_last = clr_act_q && (clr_idx_q == `CHAN_IDX_LAST);
  reg [1:0] clr_pick;
  always @* begin
    clr_pick = 2'h0;
    for (gi_pick = NGRP - 1; gi_pick >= 0; gi_pick = gi_pick - 1) begin
      if (need_clr[gi_pick])
        clr_pick = gi_pick[1:0];
    end
  end

  // one group at a time sweeps all 64 slots from index zero; a frame must outlast 64 cycles per group
  always @(posedge REF_CLK_I) begin
    if (SYS_RST_I) begin
      clr_act_q <= 1'b0;
      clr_idx_q <= 6'h00;
      clr_grp_q <= 2'h0;
      swept_q <= 4'h0;
    end else begin
      for (gi_swp = 0; gi_swp < NGRP; gi_swp = gi_swp + 1) begin
        if (pwr_rise[gi_swp])
          swept_q[gi_swp] <= 1'b0;
        else if (clr_last && clr_grp_q == gi_swp[1:0])
          swept_q[gi_swp] <= 1'b1;
      end
      if (clr_act_q) begin
        // a new power rise of the swept group restarts its sweep
        clr_idx_q <= pwr_rise[clr_grp_q] ? 6'h00 : clr_idx_q + 6'h01;
        if (clr_last && !pwr_rise[clr_grp_q])
          clr_act_q <= 1'b0;
      end else if (clr_go) begin
        clr_act_q <= 1'b1;
        clr_grp_q <= clr_pick;
        clr_idx_q <= 6'h00;
      end
    end
  end

  // broadcast write sweeps four groups, one per cycle
  reg [1:0] bc_cnt_q;
  reg bc_act_q;
  reg [5:0] bc_idx_q;
  reg [7:0] bc_dat_q;
  always @(posedge REF_CLK_I) begin
    if (SYS_RST_I) begin
      bc_act_q <= 1'b0;
      bc_cnt_q <= 2'h0;
      bc_idx_q <= 6'h00;
      bc_dat_q <= 8'h00;
    end else if (wr_chan && bcast && awaddr_q[9:8] == 2'h0) begin
      bc_act_q <= 1'b1;
      bc_cnt_q <= 2'h1;
      bc_idx_q <= awaddr_q[7:2];
      bc_dat_q <= wdata_q;
    end else if (bc_act_q) begin
      bc_cnt_q <= bc_cnt_q + 2'h1;
      if (bc_cnt_q == 2'h3)
        bc_act_q <= 1'b0;
    end
  end

  reg mem_we;
  reg [7:0] mem_wa;
  reg [7:0] mem_wd;
  always @* begin
    mem_we = 1'b0;
    mem_wa = 8'h00;
    mem_wd = 8'h00;
    if (clr_act_q) begin
      mem_we = 1'b1;
      mem_wa = {clr_grp_q, clr_idx_q};
      mem_wd = `CHAN_DEFAULT;
    end else if (bc_act_q) begin
      mem_we = 1'b1;
      mem_wa = {bc_cnt_q, bc_idx_q};
      mem_wd = bc_dat_q;
    end else if (wr_chan) begin
      mem_we = 1'b1;
      mem_wa = awaddr_q[9:2];
      mem_wd = wdata_q;
    end
  end
  // early writes may be overwritten by init presets
  wire [7:0] mem_rd;

  chan_mem #(
    .AW(8)
  ) u_chan_mem (
    .clk_i(REF_CLK_I),
    .we_i(mem_we),
    .waddr_i(mem_wa),
    .wdata_i(mem_wd),
    .raddr_i(S_AXI_ARADDR_I[9:2]),
    .rdata_o(mem_rd)
  );

  // ==========================================================
  // axi4-lite read channel, two-cycle answer
  reg rd_pend_q;
  reg [11:0] araddr_q;
  assign S_AXI_ARREADY_O = ~rd_pend_q & ~S_AXI_RVALID_O;
  always @(posedge REF_CLK_I) begin
    if (SYS_RST_I) begin
      rd_pend_q <= 1'b0;
      araddr_q <= 12'h000;
      S_AXI_RVALID_O <= 1'b0;
      S_AXI_RDATA_O <= 32'h00000000;
      S_AXI_RRESP_O <= `AXI_OKAY;
    end else begin
      if (S_AXI_ARVALID_I && S_AXI_ARREADY_O) begin
        rd_pend_q <= 1'b1;
        araddr_q <= S_AXI_ARADDR_I;
      end
      if (rd_pend_q) begin
        rd_pend_q <= 1'b0;
        S_AXI_RVALID_O <= 1'b1;
        S_AXI_RRESP_O <= `AXI_OKAY;
        case (araddr_q)
          `MAIN_CTL0_ADDR: S_AXI_RDATA_O <= {24'h000000, main_q[0]};
          `MAIN_CTL1_ADDR: S_AXI_RDATA_O <= {24'h000000, main_q[1]};
          `MAIN_CTL2_ADDR: S_AXI_RDATA_O <= {24'h000000, main_q[2]};
          `MAIN_CTL3_ADDR: S_AXI_RDATA_O <= {24'h000000, main_q[3]};
          `INT_STAT_ADDR: S_AXI_RDATA_O <= {24'h000000, int_stat_q};
          `INT_MASK_ADDR: S_AXI_RDATA_O <= {24'h000000, int_mask_q};
          `GRP_STAT_ADDR: S_AXI_RDATA_O <= {24'h000000, init_busy_q, pwr};
          default: begin
            if (in_chan(araddr_q)) begin
              S_AXI_RDATA_O <= {24'h000000, mem_rd};
            end else begin
              S_AXI_RDATA_O <= 32'h00000000;
              S_AXI_RRESP_O <= `AXI_SLVERR;
            end
          end
        endcase
      end else if (S_AXI_RVALID_O && S_AXI_RREADY_I) begin
        S_AXI_RVALID_O <= 1'b0;
      end
    end
  end

  // ==========================================================
  // pcm path: bypass with two-frame delay for every group, powered up or not
  reg [3:0] rx_d1_q, tx_d1_q;
  always @(posedge REF_CLK_I) begin
    if (SYS_RST_I) begin
      rx_d1_q <= 4'h0;
      tx_d1_q <= 4'h0;
      RX_OUT_O <= 4'h0;
      TX_OUT_O <= 4'h0;
      FMT_G711_O <= 4'h0;
      LAW_ALAW_O <= 4'h0;
      GRP_ACTIVE_O <= 4'h0;
      COEF_CLEAR_O <= 4'h0;
    end else begin
      if (frame_tick) begin
        rx_d1_q <= ri_s2_q;
        tx_d1_q <= ti_s2_q;
        RX_OUT_O <= rx_d1_q;
        TX_OUT_O <= tx_d1_q;
      end
      for (gi_out = 0; gi_out < NGRP; gi_out = gi_out + 1) begin
        FMT_G711_O[gi_out] <= main_q[gi_out][`BIT_FMT];
        LAW_ALAW_O[gi_out] <= main_q[gi_out][`BIT_LAW];
        GRP_ACTIVE_O[gi_out] <= pwr[gi_out] & ~init_busy_q[gi_out];
        COEF_CLEAR_O[gi_out] <= init_busy_q[gi_out];
      end
    end
  end

  // outputs driven only while register bit and pin are both set
  assign RX_OUT_OE_O = {4{main_q[0][`BIT_ODE] & ode_pin_q[1]}};
  assign TX_OUT_OE_O = {4{main_q[0][`BIT_ODE] & ode_pin_q[1]}};
endmodule // echo_group_main_control
`default_nettype wire
